/* File: pkg/pdb_pkg.sv */
// Package with register map, field layout and reset values of the boost and swap bank
package pdb_pkg;
  // Register offsets: 0xF8 is a multiple of four, 0xFA is not, so indices scale by four
  localparam logic [7:0] BOOST_IDX = 8'hF8;
  localparam logic [7:0] SWAP_IDX = 8'hFA;
  localparam logic [9:0] BOOST_ADDR = {BOOST_IDX, 2'b00};
  localparam logic [9:0] SWAP_ADDR = {SWAP_IDX, 2'b00};
  localparam int ADDR_W = 10;
  localparam int REG_W = 8;
  localparam int NUM_DS = 4;
  localparam int BOOST_W = 2;
  localparam int NUM_SWAP = 5;
  localparam logic [7:0] BOOST_RST = 8'h00;
  localparam logic [7:0] SWAP_RST = 8'h00;
  localparam logic [7:0] SWAP_USED_MASK = 8'h1F;
  localparam int SWAP_UP_BIT = 0;
  localparam int DRV1_LSB = 0;
  localparam int DRV2_LSB = 2;
  localparam int DRV3_LSB = 4;
  localparam int DRV4_LSB = 6;
  localparam logic [7:0] BOOST_USED_MASK = 8'hFF;
  typedef enum logic [1:0] {
    PDB_DRIVE_NORMAL = 2'h0,
    PDB_DRIVE_LOW = 2'h1,
    PDB_DRIVE_MEDIUM = 2'h2,
    PDB_DRIVE_HIGH = 2'h3
  } pdb_drive_t;
endpackage : pdb_pkg

/* File: design/pdb_reg8.sv */
// One 8-bit software register with write mask and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module pdb_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] q_ff;
  logic [7:0] nxt_q;
  always_comb begin
    nxt_q = q_ff;
    if (wr_en) begin
      nxt_q = wr_data & WR_MASK;
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign q = q_ff;
endmodule : pdb_reg8
`default_nettype wire

/* File: design/pdb_swap_lane.sv */
// Per-port data pin role selector for one transceiver
`timescale 1ns/1ps
`default_nettype none
module pdb_swap_lane (
  input wire logic clock,
  input wire logic rstn,
  input wire logic swap,
  output logic role_exchange
);
  logic role_ff;
  logic nxt_role;
  always_comb begin
    nxt_role = swap;
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      role_ff <= 1'b0;
    end else begin
      role_ff <= nxt_role;
    end
  end
  assign role_exchange = role_ff;
endmodule : pdb_swap_lane
`default_nettype wire

/* File: design/pdb_port_drive_boost_and_swap_cfg.sv */
// Boost and data pin swap configuration bank with APB slave
//
// Overview of operation
// [R1] Bits 7:6 set port four boost
// [R2] Bits 5:4 set port three boost
// [R3] Bits 3:2 set port two boost
// [R4] Bits 1:0 set port one boost
// [R5] Codes: none, low, medium, high boost
// [R6] Software should keep boost at zero
// [R7] Swap bit one exchanges pin roles
// [R8] Swap bit 0 drives upstream port
// [R9] Bits 1,2,4 drive downstream ports 1,2,4
// [R10] Swap bits 7:5 reserved, no effect
// [R11] Swap bit 3 drives downstream port three
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pdb_port_drive_boost_and_swap_cfg (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] port_one_drive_level,
  output logic [1:0] port_two_drive_level,
  output logic [1:0] port_three_drive_level,
  output logic [1:0] port_four_drive_level,
  output logic [4:0] pin_role_exchange
);
  logic [7:0] downstream_drive_boost;
  logic [7:0] data_pin_swap;
  logic boost_hit;
  logic swap_hit;
  logic wr_ok;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [7:0] drive_ff;
  logic [7:0] nxt_drive;

  // Address decode on the full word address; other bits must be zero
  always_comb begin
    boost_hit = 1'b0;
    swap_hit = 1'b0;
    if (paddr == {22'h000000, pdb_pkg::BOOST_ADDR}) begin
      boost_hit = 1'b1;
    end else if (paddr == {22'h000000, pdb_pkg::SWAP_ADDR}) begin
      swap_hit = 1'b1;
    end
  end

  // Write lands at the access edge; a strobe on lane 0 is needed since data is 8 bits
  assign wr_ok = psel && penable && pwrite && pstrb[0];

  // Every boost bit is a live field, so nothing is masked here
  pdb_reg8 #(
    .RST_VAL(pdb_pkg::BOOST_RST),
    .WR_MASK(pdb_pkg::BOOST_USED_MASK)
  ) u_boost (
    .clock(clock),
    .rstn(rstn),
    .wr_en(wr_ok && boost_hit),
    .wr_data(pwdata[7:0]),
    .q(downstream_drive_boost)
  );

  // Reserved bits are masked so they read zero and can never reach a port
  pdb_reg8 #(
    .RST_VAL(pdb_pkg::SWAP_RST),
    .WR_MASK(pdb_pkg::SWAP_USED_MASK)
  ) u_swap (
    .clock(clock),
    .rstn(rstn),
    .wr_en(wr_ok && swap_hit),
    .wr_data(pwdata[7:0]),
    .q(data_pin_swap) // [R10]
  );

  // Zero-wait slave: pready rises in the first access cycle, one cycle after setup
  always_comb begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h00000000;
    if (psel && !penable) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !(boost_hit || swap_hit);
      if (!pwrite && boost_hit) begin
        nxt_prdata = {24'h000000, downstream_drive_boost};
      end else if (!pwrite && swap_hit) begin
        nxt_prdata = {24'h000000, data_pin_swap};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Field code passes unchanged to the transceiver, which applies the pdb_drive_t meaning
  always_comb begin
    nxt_drive = downstream_drive_boost; // [R5]
  end

  // Registered copy keeps every pin level straight from a flip-flop
  always_ff @(posedge clock) begin
    if (!rstn) begin
      drive_ff <= pdb_pkg::BOOST_RST;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign port_four_drive_level = drive_ff[pdb_pkg::DRV4_LSB +: pdb_pkg::BOOST_W]; // [R1]
  assign port_three_drive_level = drive_ff[pdb_pkg::DRV3_LSB +: pdb_pkg::BOOST_W]; // [R2]
  assign port_two_drive_level = drive_ff[pdb_pkg::DRV2_LSB +: pdb_pkg::BOOST_W]; // [R3]
  assign port_one_drive_level = drive_ff[pdb_pkg::DRV1_LSB +: pdb_pkg::BOOST_W]; // [R4]

  // Bit 0 upstream, bits 1..4 downstream ports one to four
  genvar gi;
  generate
    for (gi = 0; gi < pdb_pkg::NUM_SWAP; gi++) begin : g_lane
      pdb_swap_lane u_lane (
        .clock(clock),
        .rstn(rstn),
        .swap(data_pin_swap[gi]), // [R7] [R8] [R9] [R11]
        .role_exchange(pin_role_exchange[gi])
      );
    end
  endgenerate

  // A write shows on the pins two edges after its access edge
  property p_boost_follow;
    @(posedge clock) disable iff (!rstn)
    (wr_ok && boost_hit) |-> ##2 (port_four_drive_level == $past(pwdata[7:6], 2))
      && (port_three_drive_level == $past(pwdata[5:4], 2));
  endproperty
  a_boost_follow: assert property (p_boost_follow) else $error("boost hi fields wrong"); // [R1]

  property p_boost_three;
    @(posedge clock) disable iff (!rstn)
    (wr_ok && boost_hit) |-> ##2 port_three_drive_level == $past(pwdata[5:4], 2);
  endproperty
  a_boost_three: assert property (p_boost_three) else $error("port three boost wrong"); // [R2]

  property p_boost_low;
    @(posedge clock) disable iff (!rstn)
    (wr_ok && boost_hit) |-> ##2 (port_two_drive_level == $past(pwdata[3:2], 2))
      && (port_one_drive_level == $past(pwdata[1:0], 2));
  endproperty
  a_boost_low: assert property (p_boost_low) else $error("boost lo fields wrong"); // [R3]

  property p_boost_one;
    @(posedge clock) disable iff (!rstn)
    (wr_ok && boost_hit) |-> ##2 port_one_drive_level == $past(pwdata[1:0], 2);
  endproperty
  a_boost_one: assert property (p_boost_one) else $error("port one boost wrong"); // [R4]

  // Three quiet edges are needed: a write two edges back still moves the pins
  property p_boost_stable;
    @(posedge clock) disable iff (!rstn)
    !(wr_ok && boost_hit) [*3] |-> $stable(drive_ff);
  endproperty
  a_boost_stable: assert property (p_boost_stable) else $error("boost changed unwritten"); // [R5]

  sequence s_swap_write;
    wr_ok && swap_hit;
  endsequence

  property p_swap_follow;
    @(posedge clock) disable iff (!rstn)
    s_swap_write |-> ##2 pin_role_exchange == $past(pwdata[4:0], 2);
  endproperty
  a_swap_follow: assert property (p_swap_follow) else $error("swap lanes wrong"); // [R7]

  property p_swap_up;
    @(posedge clock) disable iff (!rstn)
    s_swap_write |-> ##2 pin_role_exchange[pdb_pkg::SWAP_UP_BIT] == $past(pwdata[0], 2);
  endproperty
  a_swap_up: assert property (p_swap_up) else $error("upstream swap wrong"); // [R8]

  property p_swap_ds;
    @(posedge clock) disable iff (!rstn)
    s_swap_write |-> ##2 pin_role_exchange[4:1] == $past(pwdata[4:1], 2);
  endproperty
  a_swap_ds: assert property (p_swap_ds) else $error("downstream swap wrong"); // [R9]

  property p_swap_rsvd;
    @(posedge clock) disable iff (!rstn)
    1'b1 |-> data_pin_swap[7:5] == 3'h0;
  endproperty
  a_swap_rsvd: assert property (p_swap_rsvd) else $error("reserved swap bit set"); // [R10]

  property p_swap_three;
    @(posedge clock) disable iff (!rstn)
    s_swap_write |-> ##2 pin_role_exchange[3] == $past(pwdata[3], 2);
  endproperty
  a_swap_three: assert property (p_swap_three) else $error("port three swap wrong"); // [R11]

  // Pins hold still unless a swap write landed in the last three edges
  property p_swap_stable;
    @(posedge clock) disable iff (!rstn)
    !(wr_ok && swap_hit) [*3] |-> $stable(pin_role_exchange);
  endproperty
  a_swap_stable: assert property (p_swap_stable) else $error("swap changed unwritten"); // [R7]

  // Setup phase of an APB transfer; the slave answers in the very next cycle
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_read_boost;
    psel && !penable && !pwrite && boost_hit;
  endsequence

  sequence s_read_swap;
    psel && !penable && !pwrite && swap_hit;
  endsequence

  sequence s_unmapped;
    psel && !penable && !(boost_hit || swap_hit);
  endsequence

  property p_ready_once;
    @(posedge clock) disable iff (!rstn)
    s_setup |=> pready ##1 !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready not one cycle");

  property p_rd_boost;
    @(posedge clock) disable iff (!rstn)
    s_read_boost |=> pready && (prdata == {24'h000000, $past(downstream_drive_boost)});
  endproperty
  a_rd_boost: assert property (p_rd_boost) else $error("boost read data wrong");

  property p_rd_swap;
    @(posedge clock) disable iff (!rstn)
    s_read_swap |=> pready && (prdata == {24'h000000, $past(data_pin_swap)});
  endproperty
  a_rd_swap: assert property (p_rd_swap) else $error("swap read data wrong");

  // An unmapped address is refused with an error and reads as zero
  property p_err_unmapped;
    @(posedge clock) disable iff (!rstn)
    s_unmapped |=> pready && pslverr && (prdata == 32'h00000000);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

  property p_err_mapped;
    @(posedge clock) disable iff (!rstn)
    (psel && !penable && (boost_hit || swap_hit)) |=> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  // Outside the answer cycle the bus outputs rest at zero
  property p_idle_quiet;
    @(posedge clock) disable iff (!rstn)
    !pready |-> (prdata == 32'h00000000) && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus outputs not idle");

  // A write without the low byte strobe must leave both registers alone
  property p_wr_nostrb;
    @(posedge clock) disable iff (!rstn)
    (psel && penable && pwrite && !pstrb[0])
      |=> $stable(downstream_drive_boost) && $stable(data_pin_swap);
  endproperty
  a_wr_nostrb: assert property (p_wr_nostrb) else $error("unstrobed write landed");

  // Pin levels lag the registers by exactly one cycle
  property p_drive_track;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> drive_ff == $past(downstream_drive_boost);
  endproperty
  a_drive_track: assert property (p_drive_track) else $error("drive lag wrong"); // [R5]

  property p_role_track;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> pin_role_exchange == $past(data_pin_swap[4:0]);
  endproperty
  a_role_track: assert property (p_role_track) else $error("role lag wrong"); // [R9]

  // Not disabled by reset: it checks what reset itself leaves behind
  property p_reset_quiet;
    @(posedge clock)
    !rstn |=> (drive_ff == pdb_pkg::BOOST_RST) && (pin_role_exchange == 5'h00)
      && !pready && !pslverr && (prdata == 32'h00000000);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
endmodule : pdb_port_drive_boost_and_swap_cfg
`default_nettype wire

/* File: dv/tb_port_drive_boost_and_swap_cfg.sv */
// Testbench for the boost and data pin swap configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_port_drive_boost_and_swap_cfg;
  localparam logic [31:0] BA = 32'(pdb_pkg::BOOST_ADDR);
  localparam logic [31:0] SA = 32'(pdb_pkg::SWAP_ADDR);
  localparam logic [31:0] UA = 32'h000003E4;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] d1, d2, d3, d4;
  logic [4:0] pin_role_exchange;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  int err_total = 0;
  int checks = 0;

  pdb_port_drive_boost_and_swap_cfg i_pdb_port_drive_boost_and_swap_cfg (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_one_drive_level(d1), .port_two_drive_level(d2),
    .port_three_drive_level(d3), .port_four_drive_level(d4),
    .pin_role_exchange(pin_role_exchange)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request is held until pready is sampled high; read data taken at that edge only
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a wait that never ends
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, exp, rd);
    chk("pslverr", 32'h0, 32'(er));
  endtask : rchk

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rchk("boost reset", BA, 32'h0);
    rchk("swap reset", SA, 32'h0);
    chk("levels reset", 32'h0, {16'h0, d4, d3, d2, d1, 3'h0, pin_role_exchange});
    $display("Test reset done");
    // Each field gets a different code so a swapped field shows up
    for (int k = 0; k < 4; k++) begin
      v = {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)};
      apb(1'b1, BA, {24'h0, v}, 4'hF);
      chk("boost write err", 32'h0, 32'(er));
      rchk("boost reg", BA, {24'h0, v});
      chk("drive levels", {24'h0, v}, {24'h0, d4, d3, d2, d1});
    end
    $display("Test boost done");
    for (int i = 0; i < 8; i++) begin
      v = 8'(1 << i);
      apb(1'b1, SA, {24'hFFFFFF, v}, 4'h1);
      chk("swap write err", 32'h0, 32'(er));
      rchk("swap reg", SA, {24'h0, v & 8'h1F});
      chk("role exchange", {27'h0, v[4:0]}, {27'h0, pin_role_exchange});
    end
    apb(1'b1, SA, 32'hFF, 4'h1);
    rchk("swap all", SA, 32'h1F);
    chk("role all", 32'h1F, {27'h0, pin_role_exchange});
    $display("Test swap done");
    apb(1'b1, BA, 32'hAA, 4'hE);
    rchk("boost no strobe", BA, 32'h93);
    apb(1'b1, UA, 32'h55, 4'hF);
    chk("unmapped write err", 32'h1, 32'(er));
    apb(1'b0, UA, 32'h0, 4'h0);
    chk("unmapped read err", 32'h1, 32'(er));
    chk("unmapped read data", 32'h0, rd);
    rchk("boost kept", BA, 32'h93);
    rchk("swap kept", SA, 32'h1F);
    $display("Test refusal done");
    // Leave every boost field at normal drive
    apb(1'b1, BA, 32'h0, 4'hF);
    rchk("boost normal", BA, 32'h0);
    chk("levels normal", 32'h0, {24'h0, d4, d3, d2, d1});
    $display("Test normal drive done");
    // A reset in mid-run must clear both registers and every pin level
    apb(1'b1, BA, 32'h1B, 4'hF);
    apb(1'b1, SA, 32'h15, 4'h1);
    rchk("swap set", SA, 32'h15);
    chk("levels set", 32'h00001B15, {16'h0, d4, d3, d2, d1, 3'h0, pin_role_exchange});
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    chk("levels rerun", 32'h0, {16'h0, d4, d3, d2, d1, 3'h0, pin_role_exchange});
    rchk("boost rerun", BA, 32'h0);
    rchk("swap rerun", SA, 32'h0);
    $display("Test mid reset done");
    test_done();
  end
endmodule : tb_port_drive_boost_and_swap_cfg
`default_nettype wire
